// >>> rtl/fsc_pkg.sv
// Constants shared by the serial-flash status and address instruction block.
// Assumes a 100 MHz system clock and a single-lane SPI link in clock mode 0.
package fsc_pkg;

  localparam int SYS_CLK_PERIOD_NS     = 10;
  // Self-timed non-volatile status write cycle, in ns
  localparam int STATUS_WRITE_CYCLE_NS = 10_000_000;
  // Least time, so rounded up to whole cycles
  localparam int STATUS_WRITE_CYCLES   = (STATUS_WRITE_CYCLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS    = 8'h04;
  localparam logic [7:0] OP_VOL_ENABLE   = 8'h50;
  localparam logic [7:0] OP_WR_SR1       = 8'h01;
  localparam logic [7:0] OP_WR_SR2       = 8'h31;
  localparam logic [7:0] OP_WR_SR3       = 8'h11;
  localparam logic [7:0] OP_RD_SR1       = 8'h05;
  localparam logic [7:0] OP_RD_SR2       = 8'h35;
  localparam logic [7:0] OP_RD_SR3       = 8'h15;
  localparam logic [7:0] OP_RD_UPPER     = 8'hc8;
  localparam logic [7:0] OP_WR_UPPER     = 8'hc5;
  localparam logic [7:0] OP_ENTER_4B     = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B      = 8'he9;
  localparam logic [7:0] OP_READ         = 8'h03;
  localparam logic [7:0] OP_FAST_READ    = 8'h0b;
  localparam logic [7:0] OP_READ_4B      = 8'h13;
  localparam logic [7:0] OP_FAST_READ_4B = 8'h0c;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET        = 8'h99;

  // Status bit positions
  localparam int SR1_BUSY_BIT      = 0;
  localparam int SR1_LATCH_BIT     = 1;
  localparam int SR3_MODE_BIT      = 0;
  localparam int SR3_BOOT_MODE_BIT = 1;

  // Writable fields: protect bits in SR1; protect, lock and otp bits in SR2; drive, scheme, power-up mode in SR3
  localparam logic [7:0] SR1_WR_MASK  = 8'h7c;
  localparam logic [7:0] SR2_WR_MASK  = 8'h79;
  localparam logic [7:0] SR2_OTP_MASK = 8'h38;
  localparam logic [7:0] SR3_WR_MASK  = 8'h66;

  localparam logic [7:0] SR_RESET    = 8'h00;
  localparam logic [7:0] UPPER_RESET = 8'h00;

  // Frame shapes, counted in whole bytes; frame lengths include the opcode, field sizes do not
  localparam logic [3:0] OPCODE_BYTES = 4'h1;
  localparam logic [3:0] LEN_ALONE    = 4'h1;
  localparam logic [3:0] LEN_ONE_DATA = 4'h2;
  localparam logic [3:0] LEN_TWO_DATA = 4'h3;
  localparam logic [3:0] ADDR3_BYTES  = 4'h3;
  localparam logic [3:0] ADDR4_BYTES  = 4'h4;
  // Eight dummy clocks of fast read
  localparam logic [3:0] DUMMY_BYTES  = 4'h1;

  // Source of the outgoing byte stream
  typedef enum logic [5:0] {
    SRC_NONE = 6'h01,
    SRC_SR1  = 6'h02,
    SRC_SR2  = 6'h04,
    SRC_SR3  = 6'h08,
    SRC_UPR  = 6'h10,
    SRC_ARR  = 6'h20
  } fsc_src_e;

endpackage

// >>> rtl/fsc_sync.sv
// Two-flop level synchroniser, one chain per bit.
// Assumes the input is a level that stays put for several destination clocks.
`timescale 1ns/1ns
module fsc_sync #(
  parameter int   WIDTH     = 1,
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[i] <= RESET_VAL;
          q[i]    <= RESET_VAL;
        end else if (ce) begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate

endmodule // fsc_sync

// >>> rtl/fsc_cycle_timer.sv
// Self-timed cycle: busy for exactly CYCLES enabled clocks after start.
// Assumes start is a one-cycle pulse; a start while busy is ignored.
`timescale 1ns/1ns
module fsc_cycle_timer #(
  parameter int CYCLES = 1
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  logic [31:0] count;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= 32'h0;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (busy) begin
        if (count == 32'(CYCLES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 32'h1;
        end
      end else if (start) begin
        busy  <= 1'b1;
        count <= 32'h0;
      end
    end
  end

endmodule // fsc_cycle_timer

// >>> rtl/fsc_flash_cmd.sv
// Serial flash status, upper-address and single-lane read instruction handling.
// Assumes SPI mode 0, sck stopped while cs_n is high, cs_n high for >= 6 sys_clk
// periods between frames, and an array that answers array_addr within half an sck.
//
// What this block does
// R01 - 01h/31h/11h write status one/two/three byte
// R02 - Only writable status fields ever change
// R03 - Set otp lock bits never clear again on a status write
// R04 - Non-volatile status write needs write enable
// R05 - 50h prefix makes volatile write, latch stays
// R06 - Resets reload status from non-volatile copy
// R07 - Non-volatile write: busy for timed cycle
// R08 - Write enable latch clears when cycle ends
// R09 - Volatile write lands quickly, busy stays low
// R10 - 01h with two bytes writes both registers
// R11 - C8h shifts upper address byte out
// R12 - 3-byte mode uses upper byte as A31-24
// R13 - C5h writes upper byte, needs write enable
// R14 - Upper byte clears on power-up and resets
// R15 - 4-byte mode addresses overwrite upper byte
// R16 - Host rechecks upper byte after leaving 4-byte
// R17 - B7h enters, E9h leaves 4-byte mode
// R18 - 03h reads stream bytes, address increments
// R19 - Array reads while busy are ignored entirely
// R20 - Host keeps 03h clock at or below 50MHz
// R21 - 13h/0Ch always take 32-bit address
// R22 - Fast read inserts eight dummy clocks
// R23 - 06h alone sets write enable latch
// R24 - Status reads served at any time
// R25 - Unauthorised writes change nothing
`timescale 1ns/1ns
module fsc_flash_cmd #(
  parameter int STATUS_WRITE_CYCLES = fsc_pkg::STATUS_WRITE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        por,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_oe_n,
  output logic [31:0]      array_addr,
  input  wire logic [7:0]  array_data,
  output logic             busy,
  output logic             write_enable_latch,
  output logic             address_mode_state
);
  import fsc_pkg::*;

  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask, input logic [7:0] otp);
    // R02 writable mask
    // R03 otp bits only ever set
    merge_bits = (old_v & ~mask) | (new_v & mask) | (old_v & otp);
  endfunction

  logic        rst_any;
  logic        frame_rst;
  // System-domain state
  logic [7:0]  nv_sr1;
  logic [7:0]  nv_sr2;
  logic [7:0]  nv_sr3;
  logic [7:0]  act_sr1;
  logic [7:0]  act_sr2;
  logic [7:0]  act_sr3;
  logic [7:0]  upper_address_byte;
  logic        reload;
  logic        vol_enable;
  logic        reset_enable;
  logic        timer_done;
  logic        cs_s;
  logic        cs_d;
  logic        tog_s;
  logic        ack_s;
  logic        tog_seen;
  logic [31:0] pub_data;
  logic        pub_req;
  logic [7:0]  live_sr1;
  logic [7:0]  live_sr3;
  logic [31:0] live_word;
  // Link-domain state
  logic [2:0]  bit_cnt;
  logic [3:0]  byte_cnt;
  logic [6:0]  rx_sh;
  fsc_src_e    tx_src;
  logic [3:0]  tx_start;
  logic [3:0]  a_len;
  logic        frame_tog;
  logic [7:0]  frame_op;
  logic [7:0]  frame_d1;
  logic [7:0]  frame_d2;
  logic [3:0]  frame_bytes;
  logic        frame_whole;
  logic        rd_ignored;
  logic [23:0] addr_sh;
  logic [31:0] mirror;
  logic        ack_l;
  logic        req_l;
  logic [7:0]  tx_sh;
  logic [7:0]  m_sr1;
  logic [7:0]  m_sr2;
  logic [7:0]  m_sr3;
  logic [7:0]  m_upr;
  logic [7:0]  byte_in;
  logic        byte_done;
  fsc_src_e    dec_src;
  logic [3:0]  dec_start;
  logic [3:0]  dec_alen;
  logic [7:0]  next_tx;

  // Power loss also counts as a reset of everything volatile
  assign rst_any   = rst | por;
  // Per-frame counters restart whenever the frame is deselected
  assign frame_rst = rst_any | cs_n;

  // ---- Link domain, rising sck: shift in and decode ----
  assign byte_in   = {rx_sh, serial_data_in};
  assign byte_done = (bit_cnt == 3'h7);
  assign {m_sr1, m_sr2, m_sr3, m_upr} = mirror;

  always_comb begin
    dec_src   = SRC_NONE;
    dec_alen  = m_sr3[SR3_MODE_BIT] ? ADDR4_BYTES : ADDR3_BYTES;
    dec_start = OPCODE_BYTES;
    case (byte_in)
      // R24 status reads always served
      OP_RD_SR1:   dec_src = SRC_SR1;
      OP_RD_SR2:   dec_src = SRC_SR2;
      OP_RD_SR3:   dec_src = SRC_SR3;
      // R11 upper byte read
      OP_RD_UPPER: dec_src = SRC_UPR;
      // R18 address length follows mode
      OP_READ: begin
        dec_src   = SRC_ARR;
        dec_start = OPCODE_BYTES + dec_alen;
      end
      // R22 one dummy byte
      OP_FAST_READ: begin
        dec_src   = SRC_ARR;
        dec_start = OPCODE_BYTES + dec_alen + DUMMY_BYTES;
      end
      // R21 always 32-bit address
      OP_READ_4B: begin
        dec_src   = SRC_ARR;
        dec_alen  = ADDR4_BYTES;
        dec_start = OPCODE_BYTES + ADDR4_BYTES;
      end
      OP_FAST_READ_4B: begin
        dec_src   = SRC_ARR;
        dec_alen  = ADDR4_BYTES;
        dec_start = OPCODE_BYTES + ADDR4_BYTES + DUMMY_BYTES;
      end
      default: dec_src = SRC_NONE;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 4'h0;
      rx_sh    <= 7'h0;
      tx_src   <= SRC_NONE;
      tx_start <= 4'h0;
      a_len    <= 4'h0;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh   <= byte_in[6:0];
      if (byte_done) begin
        if (byte_cnt != 4'hf) begin
          byte_cnt <= byte_cnt + 4'h1;
        end
        if (byte_cnt == 4'h0) begin
          // R19 array read dropped while busy
          tx_src   <= (dec_src == SRC_ARR && m_sr1[SR1_BUSY_BIT]) ? SRC_NONE : dec_src;
          tx_start <= dec_start;
          a_len    <= dec_alen;
        end
      end
    end
  end

  // Frame record: survives cs_n rising so the system side can act on it
  always_ff @(posedge sck or posedge rst_any) begin
    if (rst_any) begin
      frame_tog   <= 1'b0;
      frame_op    <= 8'h0;
      frame_d1    <= 8'h0;
      frame_d2    <= 8'h0;
      frame_bytes <= 4'h0;
      frame_whole <= 1'b0;
      rd_ignored  <= 1'b0;
      addr_sh     <= 24'h0;
    end else begin
      frame_whole <= byte_done;
      frame_bytes <= (byte_done && byte_cnt != 4'hf) ? byte_cnt + 4'h1 : byte_cnt;
      if (bit_cnt == 3'h0 && byte_cnt == 4'h0) begin
        frame_tog <= ~frame_tog;
      end
      if (byte_done) begin
        addr_sh <= {addr_sh[15:0], byte_in};
        if (byte_cnt == 4'h0) begin
          frame_op   <= byte_in;
          rd_ignored <= (dec_src == SRC_ARR) && m_sr1[SR1_BUSY_BIT];
        end
        if (byte_cnt == 4'h1) begin
          frame_d1 <= byte_in;
        end
        if (byte_cnt == 4'h2) begin
          frame_d2 <= byte_in;
        end
      end
    end
  end

  always_ff @(posedge sck or posedge rst_any) begin
    if (rst_any) begin
      array_addr <= 32'h0;
    end else if (byte_done && tx_src == SRC_ARR) begin
      if (byte_cnt == a_len) begin
        // R12 upper byte supplies A31-24 in 3-byte mode
        array_addr <= (a_len == ADDR4_BYTES) ? {addr_sh, byte_in} : {m_upr, addr_sh[15:0], byte_in};
      end else if (byte_cnt >= tx_start) begin
        // R18 address increments per byte
        array_addr <= array_addr + 32'h1;
      end
    end
  end

  // Word crossing: the system side holds pub_data steady until acknowledged
  fsc_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
    .clk (sck),
    .rst (rst_any),
    .ce  (1'b1),
    .d   (pub_req),
    .q   (req_l)
  );

  always_ff @(posedge sck or posedge rst_any) begin
    if (rst_any) begin
      mirror <= 32'h0;
      ack_l  <= 1'b0;
    end else if (req_l != ack_l) begin
      mirror <= pub_data;
      ack_l  <= req_l;
    end
  end

  // ---- Link domain, falling sck: shift out ----
  always_comb begin
    case (tx_src)
      SRC_SR1: next_tx = m_sr1;
      SRC_SR2: next_tx = m_sr2;
      SRC_SR3: next_tx = m_sr3;
      SRC_UPR: next_tx = m_upr;
      SRC_ARR: next_tx = array_data;
      default: next_tx = 8'h0;
    endcase
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sh            <= 8'h0;
      serial_data_out  <= 1'b0;
      serial_data_oe_n <= 1'b1;
    end else if (bit_cnt == 3'h0 && tx_src != SRC_NONE && byte_cnt >= tx_start) begin
      // R11 MSB first on falling edges; bytes repeat until deselect
      tx_sh            <= {next_tx[6:0], 1'b0};
      serial_data_out  <= next_tx[7];
      serial_data_oe_n <= 1'b0;
    end else if (!serial_data_oe_n) begin
      tx_sh           <= {tx_sh[6:0], 1'b0};
      serial_data_out <= tx_sh[7];
    end
  end

  // ---- System domain ----
  fsc_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_cs_sync (
    .clk (sys_clk),
    .rst (rst_any),
    .ce  (ce),
    .d   (cs_n),
    .q   (cs_s)
  );

  fsc_sync #(.WIDTH(2), .RESET_VAL(1'b0)) u_ev_sync (
    .clk (sys_clk),
    .rst (rst_any),
    .ce  (ce),
    .d   ({frame_tog, ack_l}),
    .q   ({tog_s, ack_s})
  );

  logic frame_go;
  logic frame_ok;
  logic sr_write;
  logic vol_go;
  logic nv_go;
  logic is_alone;
  logic sw_reset;
  logic ear_track;

  // A frame counts once: cs_n rose and at least one sck edge happened in it
  assign frame_go  = cs_s && !cs_d && (tog_s != tog_seen);
  assign frame_ok  = frame_go && frame_whole;
  assign is_alone  = frame_ok && (frame_bytes == LEN_ALONE);
  // R01 R10 one or two data bytes
  assign sr_write  = frame_ok && (((frame_op == OP_WR_SR1) &&
                                   (frame_bytes == LEN_ONE_DATA || frame_bytes == LEN_TWO_DATA)) ||
                                  ((frame_op == OP_WR_SR2 || frame_op == OP_WR_SR3) &&
                                   frame_bytes == LEN_ONE_DATA));
  // R05 volatile path
  assign vol_go    = sr_write && vol_enable;
  // R04 R25 non-volatile path needs latch
  assign nv_go     = sr_write && !vol_enable && write_enable_latch && !busy;
  assign sw_reset  = is_alone && (frame_op == OP_RESET) && reset_enable;
  // R15 4-byte addresses overwrite upper byte
  assign ear_track = frame_go && !rd_ignored && address_mode_state && (frame_bytes >= LEN_ONE_DATA) &&
                     (frame_op == OP_READ || frame_op == OP_FAST_READ ||
                      frame_op == OP_READ_4B || frame_op == OP_FAST_READ_4B);

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      cs_d     <= 1'b1;
      tog_seen <= 1'b0;
    end else if (ce) begin
      cs_d <= cs_s;
      if (cs_s && !cs_d) begin
        tog_seen <= tog_s;
      end
    end
  end

  // Non-volatile copy is lost only by power loss
  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      nv_sr1 <= SR_RESET;
      nv_sr2 <= SR_RESET;
      nv_sr3 <= SR_RESET;
    end else if (ce && nv_go) begin
      if (frame_op == OP_WR_SR1) begin
        nv_sr1 <= merge_bits(nv_sr1, frame_d1, SR1_WR_MASK, 8'h00);
      end
      if (frame_op == OP_WR_SR2 || (frame_op == OP_WR_SR1 && frame_bytes == LEN_TWO_DATA)) begin
        nv_sr2 <= merge_bits(nv_sr2, (frame_op == OP_WR_SR2) ? frame_d1 : frame_d2,
                             SR2_WR_MASK, SR2_OTP_MASK);
      end
      if (frame_op == OP_WR_SR3) begin
        nv_sr3 <= merge_bits(nv_sr3, frame_d1, SR3_WR_MASK, 8'h00);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      act_sr1 <= SR_RESET;
      act_sr2 <= SR_RESET;
      act_sr3 <= SR_RESET;
      reload  <= 1'b1;
    end else if (ce) begin
      if (reload || sw_reset) begin
        // R06 reload from non-volatile copy
        act_sr1 <= nv_sr1;
        act_sr2 <= nv_sr2;
        act_sr3 <= nv_sr3;
        reload  <= 1'b0;
      end else if (vol_go || nv_go) begin
        // R09 volatile values land at once
        if (frame_op == OP_WR_SR1) begin
          act_sr1 <= merge_bits(act_sr1, frame_d1, SR1_WR_MASK, 8'h00);
        end
        // R10 second byte goes to register two
        if (frame_op == OP_WR_SR2 || (frame_op == OP_WR_SR1 && frame_bytes == LEN_TWO_DATA)) begin
          act_sr2 <= merge_bits(act_sr2, (frame_op == OP_WR_SR2) ? frame_d1 : frame_d2,
                                SR2_WR_MASK, SR2_OTP_MASK);
        end
        if (frame_op == OP_WR_SR3) begin
          act_sr3 <= merge_bits(act_sr3, frame_d1, SR3_WR_MASK, 8'h00);
        end
      end
    end
  end

  // R07 busy for the timed cycle after deselect
  fsc_cycle_timer #(.CYCLES(STATUS_WRITE_CYCLES)) u_wr_timer (
    .clk   (sys_clk),
    .rst   (rst_any),
    .ce    (ce),
    .start (nv_go),
    .busy  (busy),
    .done  (timer_done)
  );

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      write_enable_latch <= 1'b0;
    end else if (ce) begin
      if (is_alone && frame_op == OP_WRITE_ENABLE) begin
        // R23 set wins over cycle-end clear
        write_enable_latch <= 1'b1;
      end else if (sw_reset || timer_done || (is_alone && frame_op == OP_WRITE_DIS)) begin
        // R08 cleared at end of write cycle
        write_enable_latch <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      vol_enable   <= 1'b0;
      reset_enable <= 1'b0;
    end else if (ce && frame_go) begin
      // A prefix is good for the very next frame only
      vol_enable   <= is_alone && (frame_op == OP_VOL_ENABLE);
      reset_enable <= is_alone && (frame_op == OP_RESET_ENABLE);
    end
  end

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      address_mode_state <= 1'b0;
    end else if (ce) begin
      if (reload || sw_reset) begin
        address_mode_state <= nv_sr3[SR3_BOOT_MODE_BIT];
      end else if (is_alone && frame_op == OP_ENTER_4B) begin
        // R17 mode switch instructions
        address_mode_state <= 1'b1;
      end else if (is_alone && frame_op == OP_EXIT_4B) begin
        address_mode_state <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      // R14 cleared by power-up and reset
      upper_address_byte <= UPPER_RESET;
    end else if (ce) begin
      if (sw_reset) begin
        upper_address_byte <= UPPER_RESET;
      end else if (frame_ok && frame_op == OP_WR_UPPER && frame_bytes == LEN_ONE_DATA &&
                   write_enable_latch) begin
        // R13 write needs the latch
        upper_address_byte <= frame_d1;
      end else if (ear_track) begin
        upper_address_byte <= frame_d1;
      end
    end
  end

  always_comb begin
    live_sr1               = act_sr1;
    live_sr1[SR1_BUSY_BIT] = busy;
    live_sr1[SR1_LATCH_BIT] = write_enable_latch;
    live_sr3                = act_sr3;
    live_sr3[SR3_MODE_BIT]  = address_mode_state;
  end

  assign live_word = {live_sr1, act_sr2, live_sr3, upper_address_byte};

  // Publishes a fresh copy whenever the live word differs and the previous one has been taken
  always_ff @(posedge sys_clk or posedge rst_any) begin
    if (rst_any) begin
      pub_data <= 32'h0;
      pub_req  <= 1'b0;
    end else if (ce && ack_s == pub_req && pub_data != live_word) begin
      pub_data <= live_word;
      pub_req  <= ~pub_req;
    end
  end

endmodule // fsc_flash_cmd

// >>> bench/fsc_cmd_checker.sv
// Port-level checker for fsc_flash_cmd.
// Assumes ce is held high, so busy length is counted in plain sys_clk cycles.
`timescale 1ns/1ns
module fsc_cmd_checker #(
  parameter int STATUS_WRITE_CYCLES = 1
) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        por,
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        serial_data_in,
  input wire logic        serial_data_out,
  input wire logic        serial_data_oe_n,
  input wire logic [31:0] array_addr,
  input wire logic [7:0]  array_data,
  input wire logic        busy,
  input wire logic        write_enable_latch,
  input wire logic        address_mode_state
);
  logic [31:0] bcnt;
  logic [5:0]  bits;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || por);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst) bcnt <= 32'h0;
    else bcnt <= busy ? bcnt + 32'h1 : 32'h0;
  // Link bit count, cleared whenever the frame ends
  always_ff @(posedge sck or posedge cs_n)
    if (cs_n) bits <= 6'h0;
    else if (bits != 6'h3f) bits <= bits + 6'h1;
  a_busy_length: assert property ($fell(busy) |-> bcnt == STATUS_WRITE_CYCLES)
    else $error("busy length wrong");
  a_latch_at_end: assert property ($fell(busy) |=> !write_enable_latch)
    else $error("latch not cleared at cycle end");
  a_busy_needs_latch: assert property ($rose(busy) |-> write_enable_latch && cs_n)
    else $error("busy without latch or inside frame");
  a_latch_after_frame: assert property ($rose(write_enable_latch) |-> cs_n)
    else $error("latch set inside frame");
  a_mode_after_frame: assert property ($changed(address_mode_state) |-> cs_n)
    else $error("mode changed inside frame");
  a_out_after_opcode: assert property (!serial_data_oe_n |-> bits >= 6'h8)
    else $error("output before opcode done");
  a_oe_idle: assert property (cs_n |-> serial_data_oe_n)
    else $error("output enabled while deselected");
  a_sdo_idle: assert property (cs_n && $past(cs_n) |-> !serial_data_out)
    else $error("data out not quiet while deselected");
  a_addr_idle: assert property (cs_n && $past(cs_n) |-> $stable(array_addr))
    else $error("array address moved while deselected");
  c_busy: cover property ($rose(busy));
  c_mode: cover property ($rose(address_mode_state));
  c_read: cover property ($fell(serial_data_oe_n));
endmodule // fsc_cmd_checker
bind fsc_flash_cmd fsc_cmd_checker #(.STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES)) i_fsc_cmd_checker (
  .sys_clk(sys_clk), .rst(rst), .ce(ce), .por(por), .sck(sck), .cs_n(cs_n), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n), .array_addr(array_addr),
  .array_data(array_data), .busy(busy), .write_enable_latch(write_enable_latch),
  .address_mode_state(address_mode_state));

// >>> bench/fsc_spi_host.sv
// SPI controller model in mode 0: sends whole bytes MSB first, then reads bytes back.
// Assumes frame is called from one process; sck stands low between frames.
`timescale 1ns/1ns
module fsc_spi_host (
  output logic      sck,
  output logic      cs_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_oe_n
);
  localparam int HALF = 80;
  logic [7:0] rx;
  logic       drove;
  event       got;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    serial_data_in = 1'b0;
  end
  task automatic frame(input logic [63:0] tx, input int nb, input int nrd);
    drove = 1'b0;
    cs_n = 1'b0;
    for (int i = 8 * nb - 1; i >= 0; i--) begin
      serial_data_in = tx[i];
      #HALF sck = 1'b1;
      #HALF sck = 1'b0;
    end
    for (int k = 0; k < nrd; k++) begin
      for (int j = 0; j < 8; j++) begin
        #HALF sck = 1'b1;
        // Undriven line shows the inverse, so a stale bit cannot pass
        rx = {rx[6:0], serial_data_oe_n ? !serial_data_out : serial_data_out};
        drove = drove | !serial_data_oe_n;
        #HALF sck = 1'b0;
      end
      -> got;
    end
    #HALF cs_n = 1'b1;
    // Released line must not hold a stale bit
    serial_data_in = !serial_data_in;
    #200;
  endtask
endmodule // fsc_spi_host

// >>> bench/tb.sv
// Self-checking bench for fsc_flash_cmd driven by the SPI controller model.
// Assumes a shortened status write cycle and an array that returns addr[7:0]^addr[31:24].
`timescale 1ns/1ns
module tb;
  localparam int WCYC = 1500;
  logic        sys_clk, rst, ce, por, sck, cs_n, serial_data_in, serial_data_out;
  logic        serial_data_oe_n, busy, write_enable_latch, address_mode_state;
  logic [31:0] array_addr, a;
  logic [7:0]  array_data;
  logic [7:0]  exp_q[$];
  int          fail_count = 0, total_checks = 0, cyc = 0;
  assign array_data = array_addr[7:0] ^ array_addr[31:24];
  fsc_flash_cmd #(.STATUS_WRITE_CYCLES(WCYC)) i_fsc_flash_cmd (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .por(por), .sck(sck), .cs_n(cs_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n), .array_addr(array_addr),
    .array_data(array_data), .busy(busy), .write_enable_latch(write_enable_latch),
    .address_mode_state(address_mode_state));
  fsc_spi_host i_fsc_spi_host (.sck(sck), .cs_n(cs_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe_n(serial_data_oe_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic close_out;
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic op(input logic [63:0] tx, input int nb, input int nrd, input logic [15:0] e);
    if (nrd == 2) exp_q.push_back(e[15:8]);
    if (nrd > 0) exp_q.push_back(e[7:0]);
    i_fsc_spi_host.frame(tx, nb, nrd);
  endtask
  task automatic flags(input logic [7:0] e);
    chk({5'h0, busy, write_enable_latch, address_mode_state}, e);
  endtask
  task automatic sys_step;
    @(posedge sys_clk);
    #2;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(i_fsc_spi_host.got) begin
    chk(i_fsc_spi_host.rx, exp_q.pop_front());
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    por = 1'b1;
    ce = 1'b1;
    void'($urandom(32'h4c45));
    repeat (20) sys_step();
    rst = 1'b0;
    por = 1'b0;
    repeat (3) sys_step();
    op(64'h05, 1, 1, 16'h0000);
    op(64'hc8, 1, 1, 16'h0000);
    op(64'h017c, 2, 0, 16'h0);
    op(64'h05, 1, 1, 16'h0000);
    op(64'h06, 1, 0, 16'h0);
    flags(8'h02);
    op(64'h01ff, 2, 0, 16'h0);
    flags(8'h06);
    op(64'h05, 1, 1, 16'h007f);
    op(64'h03000000, 4, 1, 16'h00ff);
    chk({7'h0, i_fsc_spi_host.drove}, 8'h00);
    for (int i = 0; i < 3000 && busy; i++) sys_step();
    sys_step();
    flags(8'h00);
    op(64'h05, 1, 1, 16'h007c);
    op(64'h50, 1, 0, 16'h0);
    op(64'h0100ff, 3, 0, 16'h0);
    flags(8'h00);
    op(64'h05, 1, 1, 16'h0000);
    op(64'h35, 1, 1, 16'h0079);
    op(64'h50, 1, 0, 16'h0);
    op(64'h3100, 2, 0, 16'h0);
    op(64'h35, 1, 1, 16'h0038);
    op(64'h50, 1, 0, 16'h0);
    op(64'h11ff, 2, 0, 16'h0);
    op(64'h15, 1, 1, 16'h0066);
    rst = 1'b1;
    sys_step();
    rst = 1'b0;
    repeat (3) sys_step();
    op(64'h05, 1, 1, 16'h007c);
    op(64'h35, 1, 1, 16'h0000);
    op(64'h06, 1, 0, 16'h0);
    op(64'hc5a5, 2, 0, 16'h0);
    op(64'hc8, 1, 1, 16'h00a5);
    op(64'h03123456, 4, 2, 16'hf3f2);
    op(64'hb7, 1, 0, 16'h0);
    flags(8'h03);
    op(64'h033c000010, 5, 1, 16'h002c);
    op(64'he9, 1, 0, 16'h0);
    flags(8'h02);
    op(64'hc8, 1, 1, 16'h003c);
    op(64'h0b000020ff, 5, 1, 16'h001c);
    op(64'h1301000005, 5, 1, 16'h0004);
    op(64'h0c02000007ff, 6, 1, 16'h0005);
    op(64'h50, 1, 0, 16'h0);
    op(64'h0100, 2, 0, 16'h0);
    op(64'h05, 1, 1, 16'h0002);
    op(64'h66, 1, 0, 16'h0);
    op(64'h99, 1, 0, 16'h0);
    flags(8'h00);
    op(64'hc8, 1, 1, 16'h0000);
    op(64'h05, 1, 1, 16'h007c);
    for (int i = 0; i < 4; i++) begin
      a = $urandom;
      op({24'h0, 8'h13, a}, 5, 1, {8'h0, a[7:0] ^ a[31:24]});
    end
    close_out();
  end
endmodule // tb
